// ===== hdl/rtcsc_cal.sv
// Purpose: BCD calendar counters with load-time value correction
// Assumes: One tick per second; load and tick are single-cycle pulses
// Notes: Load wins over a tick in the same cycle
`timescale 1ns/1ps
module rtcsc_cal (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count and load
  input wire logic tick,
  input wire logic load,
  input rtcsc_pkg::rtcsc_time_s load_val,
  // Current time
  output rtcsc_pkg::rtcsc_time_s time_q
);
  import rtcsc_pkg::*;

  rtcsc_time_s time_d;

  function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_in = (v[3:0] <= DIGIT_MAX) && (v[7:4] <= DIGIT_MAX) &&
             (v >= lo) && (v <= hi);
  endfunction : bcd_in

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == DIGIT_MAX) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // Every fourth year through 2099, 2000 included
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : is_leap

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    case (m)
      MON_FEB: last_day = is_leap(y) ? DAYS_29 : DAYS_28;
      MON_APR, MON_JUN, MON_SEP, MON_NOV: last_day = DAYS_30;
      default: last_day = DAYS_31;
    endcase
  endfunction : last_day

  // Out-of-range fields fall back to defaults; unused bits end up zero
  function automatic rtcsc_time_s correct(input rtcsc_time_s t);
    rtcsc_time_s c;
    c = t;
    if (!bcd_in(t.sec, BCD_ZERO, SEC_MAX)) c.sec = BCD_ZERO;
    if (!bcd_in(t.minute, BCD_ZERO, SEC_MAX)) c.minute = BCD_ZERO;
    if (!bcd_in(t.hour, BCD_ZERO, HOUR_MAX)) c.hour = BCD_ZERO;
    if (!bcd_in(t.dow, BCD_ONE, DOW_MAX)) c.dow = BCD_ONE;
    if (!bcd_in(t.month, BCD_ONE, MON_MAX)) c.month = BCD_ONE;
    if (!bcd_in(t.year, BCD_ZERO, YEAR_MAX)) c.year = BCD_ZERO;
    if (!bcd_in(t.date, BCD_ONE, last_day(c.month, c.year))) begin
      c.date = BCD_ONE;
    end
    correct = c;
  endfunction : correct

  always_comb begin
    time_d = time_q;
    if (load) begin
      time_d = correct(load_val);
    end else if (tick) begin
      // BCD ripple from seconds up to year
      time_d.sec = bcd_inc(time_q.sec);
      if (time_q.sec == SEC_MAX) begin
        time_d.sec = BCD_ZERO;
        time_d.minute = bcd_inc(time_q.minute);
        if (time_q.minute == SEC_MAX) begin
          time_d.minute = BCD_ZERO;
          time_d.hour = bcd_inc(time_q.hour);
          if (time_q.hour == HOUR_MAX) begin
            time_d.hour = BCD_ZERO;
            time_d.dow = (time_q.dow == DOW_MAX) ? BCD_ONE
                                                 : bcd_inc(time_q.dow);
            time_d.date = bcd_inc(time_q.date);
            if (time_q.date == last_day(time_q.month, time_q.year)) begin
              time_d.date = BCD_ONE;
              time_d.month = bcd_inc(time_q.month);
              if (time_q.month == MON_MAX) begin
                time_d.month = BCD_ONE;
                time_d.year = (time_q.year == YEAR_MAX) ? BCD_ZERO
                                                        : bcd_inc(time_q.year);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      time_q <= TIME_RST;
    end else begin
      time_q <= time_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_CAL_BCD: assert property (
    time_q.sec[3:0] <= DIGIT_MAX && time_q.minute[3:0] <= DIGIT_MAX &&
    time_q.date[3:0] <= DIGIT_MAX && time_q.year[3:0] <= DIGIT_MAX)
    else $error("calendar digit left BCD range");

  AST_CAL_MONTH_END: assert property (
    (tick && !load && time_q.sec == SEC_MAX && time_q.minute == SEC_MAX &&
     time_q.hour == HOUR_MAX &&
     time_q.date == last_day(time_q.month, time_q.year))
    |=> time_q.date == BCD_ONE)
    else $error("date did not wrap at month end");

endmodule : rtcsc_cal

// ===== hdl/rtcsc_pkg.sv
// Purpose: Shared constants and types of the serial calendar clock
// Assumes: Serial frames are eight bits, sent least significant bit first
// Notes: Timer data is seven BCD bytes, seconds in the lowest byte
package rtcsc_pkg;

  // Frame codes, all invalid as BCD digits
  localparam logic [7:0] START_TWR = 8'h5F;
  localparam logic [7:0] START_TRD = 8'hDF;
  localparam logic [7:0] START_CWR = 8'h9F;
  localparam logic [7:0] STOP_CODE = 8'h1F;

  // Widths of the serial data
  localparam int unsigned TIMER_BITS = 56;
  localparam int unsigned CTRL_BITS = 4;
  localparam int unsigned SHIFT_BITS = 64;
  localparam int unsigned STOP_LSB = 56;
  localparam int unsigned CTRL_LSB = 52;
  localparam logic [2:0] FRAME_LAST = 3'h7;
  localparam logic [6:0] RD_TOTAL = 7'h40;

  // Time base and wake-up timing
  localparam int unsigned TB_32K_HZ = 32000;
  localparam int unsigned TB_384K_HZ = 384000;
  localparam int unsigned WAKE_US = 720;
  localparam int unsigned US_PER_S = 1000000;

  // Control data
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam int unsigned CTRL_WAKE_EN = 0;

  // BCD limits and defaults
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DOW_MAX = 8'h07;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] dow;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] sec;
  } rtcsc_time_s;

  localparam rtcsc_time_s TIME_RST = '{8'h00, 8'h01, 8'h01, 8'h01,
                                       8'h00, 8'h00, 8'h00};

  // Data line drive: level, enable, weak pull-down
  typedef struct packed {
    logic level;
    logic drive;
    logic pull_dn;
  } rtcsc_pin_s;

  typedef enum logic [5:0] {
    ST_HUNT   = 6'b00_0001,
    ST_WR_TMR = 6'b00_0010,
    ST_WR_CTL = 6'b00_0100,
    ST_LD_TMR = 6'b00_1000,
    ST_LD_CTL = 6'b01_0000,
    ST_READ   = 6'b10_0000
  } rtcsc_state_e;

endpackage : rtcsc_pkg

// ===== hdl/rtcsc_top.sv
// Purpose: Two-wire serial front end of a BCD calendar clock with wake-up
// Assumes: Serial clock, data and time base are sampled on clk
// Notes: Serial clock must be far slower than clk for edges to be seen
//
// How it works
// - Time fields held as four-bit BCD digits
// - Month ends and leap days through 2099
// - Unused timer bits hold zero; control keeps all four written bits
// - Control-only write leaves counters untouched
// - Start code 5F enters timer write
// - Start code DF enters timer read
// - Start code 9F enters control-only write
// - Stop code 1F closes every transfer
// - Device sends read stop, then releases line
// - Frame codes are never valid BCD bytes
// - Write bits sampled on serial clock rise
// - Control write keeps last four bits
// - Control loaded on fall after stop
// - All serial data least significant first
// - Wake-up pulls low every 720 us
// - Control bit 0 governs the wake-up output
// - Time base divided down to 1 Hz
// - Host drives serial clock, low when idle
// - Pull-down only while data line input
// - Keeps seconds through two-digit year
// - Timer write halts divider, loads 56 bits
// - Read drives line, shifts 64 bits out
// - Invalid written time fields become defaults
`timescale 1ns/1ps
module rtcsc_top #(
  parameter int unsigned TIMEBASE_HZ = rtcsc_pkg::TB_32K_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // External time base
  input wire logic ext_timebase_in,
  // Serial link from host
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  output rtcsc_pkg::rtcsc_pin_s ser_data_pin,
  // Wake-up open-drain enable, high pulls the pin low
  output logic wake_pull_low
);
  import rtcsc_pkg::*;

  localparam int unsigned DIV_W = $clog2(TIMEBASE_HZ);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TIMEBASE_HZ - 1);
  localparam int unsigned WAKE_RAW = (WAKE_US * TIMEBASE_HZ) / US_PER_S;
  localparam int unsigned WAKE_TICKS = (WAKE_RAW < 1) ? 1 : WAKE_RAW;
  localparam int unsigned WK_W = $clog2(WAKE_TICKS + 1);
  localparam logic [WK_W-1:0] WAKE_LAST = WK_W'(WAKE_TICKS - 1);
  localparam logic [WK_W-1:0] WK_ZERO = '0;

  // Input synchronisers, third stage for edge detection
  logic [2:0] tb_q;
  logic [2:0] sck_q;
  logic [1:0] sd_q;
  logic tb_rise;
  logic sck_rise;
  logic sck_fall;
  logic sd;

  // Frame engine
  rtcsc_state_e state_q, state_d;
  logic [2:0] bit_q, bit_d;
  logic [SHIFT_BITS-1:0] sr_q, sr_d;
  logic [SHIFT_BITS-1:0] rd_q, rd_d;
  logic [6:0] rd_idx_q, rd_idx_d;
  logic [CTRL_BITS-1:0] ctrl_q, ctrl_d;
  rtcsc_pin_s pin_q, pin_d;
  logic frame_end;
  logic [7:0] code;
  logic cal_load_q, cal_load_d;

  // Divider and wake-up
  logic [DIV_W-1:0] div_q, div_d;
  logic div_run_q, div_run_d;
  logic tick;
  logic [WK_W-1:0] wk_q, wk_d;
  logic wake_q, wake_d;

  rtcsc_time_s time_now;

  always_ff @(posedge clk) begin
    if (rst) begin
      tb_q <= 3'h0;
      sck_q <= 3'h0;
      sd_q <= 2'h0;
    end else begin
      tb_q <= {tb_q[1:0], ext_timebase_in};
      sck_q <= {sck_q[1:0], ser_clk_in};
      sd_q <= {sd_q[0], ser_data_in};
    end
  end

  assign tb_rise = tb_q[1] && !tb_q[2];
  assign sck_rise = sck_q[1] && !sck_q[2];
  assign sck_fall = !sck_q[1] && sck_q[2];
  assign sd = sd_q[1];

  // Eighth rise of a byte; code is the byte as it completes, LSB first
  assign frame_end = sck_rise && (bit_q == FRAME_LAST);
  assign code = {sd, sr_q[SHIFT_BITS-1:SHIFT_BITS-7]};

  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    sr_d = sr_q;
    rd_d = rd_q;
    rd_idx_d = rd_idx_q;
    ctrl_d = ctrl_q;
    pin_d = pin_q;
    cal_load_d = 1'b0;
    div_run_d = div_run_q;
    if (sck_rise) begin
      bit_d = bit_q + 3'h1;
      if (state_q != ST_READ) begin
        sr_d = {sd, sr_q[SHIFT_BITS-1:1]};
      end
    end
    case (state_q)
      ST_HUNT: begin
        if (frame_end) begin
          case (code)
            START_TWR: begin
              state_d = ST_WR_TMR;
              div_run_d = 1'b0;
              sr_d = '0;
            end
            START_TRD: begin
              state_d = ST_READ;
              rd_d = {STOP_CODE, time_now};
              rd_idx_d = 7'h00;
            end
            START_CWR: state_d = ST_WR_CTL;
            default: state_d = ST_HUNT;
          endcase
        end
      end
      ST_WR_TMR: begin
        // Data bytes are BCD, so only the stop code can match
        if (frame_end && code == STOP_CODE) begin
          state_d = ST_LD_TMR;
        end
      end
      ST_WR_CTL: begin
        if (frame_end && code == STOP_CODE) begin
          state_d = ST_LD_CTL;
        end
      end
      ST_LD_TMR: begin
        if (sck_fall) begin
          cal_load_d = 1'b1;
          div_run_d = 1'b1;
          state_d = ST_HUNT;
        end
      end
      ST_LD_CTL: begin
        if (sck_fall) begin
          // Last four bits before the stop code; counters untouched
          ctrl_d = sr_q[CTRL_LSB +: CTRL_BITS];
          state_d = ST_HUNT;
        end
      end
      ST_READ: begin
        if (sck_fall) begin
          if (rd_idx_q == RD_TOTAL) begin
            pin_d = '{level: 1'b0, drive: 1'b0, pull_dn: 1'b1};
            state_d = ST_HUNT;
          end else begin
            pin_d = '{level: rd_q[0], drive: 1'b1, pull_dn: 1'b0};
            rd_d = {1'b0, rd_q[SHIFT_BITS-1:1]};
            rd_idx_d = rd_idx_q + 7'h01;
          end
        end
      end
      default: begin
        state_d = ST_HUNT;
        pin_d = '{level: 1'b0, drive: 1'b0, pull_dn: 1'b1};
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_HUNT;
      bit_q <= 3'h0;
      sr_q <= '0;
      rd_q <= '0;
      rd_idx_q <= 7'h00;
      ctrl_q <= CTRL_RST;
      pin_q <= '{level: 1'b0, drive: 1'b0, pull_dn: 1'b1};
      cal_load_q <= 1'b0;
      div_run_q <= 1'b1;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      sr_q <= sr_d;
      rd_q <= rd_d;
      rd_idx_q <= rd_idx_d;
      ctrl_q <= ctrl_d;
      pin_q <= pin_d;
      cal_load_q <= cal_load_d;
      div_run_q <= div_run_d;
    end
  end

  // One-second tick from the time base; cleared while a timer write is open
  assign tick = div_run_q && tb_rise && (div_q == DIV_LAST);

  always_comb begin
    div_d = div_q;
    if (!div_run_q) begin
      div_d = '0;
    end else if (tb_rise) begin
      div_d = (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
    end
    wk_d = wk_q;
    if (tb_rise) begin
      wk_d = (wk_q == WAKE_LAST) ? WK_ZERO : wk_q + WK_W'(1);
    end
    wake_d = ctrl_q[CTRL_WAKE_EN] && (wk_q == WK_ZERO);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
      wk_q <= WK_ZERO;
      wake_q <= 1'b0;
    end else begin
      div_q <= div_d;
      wk_q <= wk_d;
      wake_q <= wake_d;
    end
  end

  rtcsc_cal u_cal (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .load(cal_load_q),
    .load_val(rtcsc_time_s'(sr_q[TIMER_BITS-1:0])),
    .time_q(time_now)
  );

  assign ser_data_pin = pin_q;
  assign wake_pull_low = wake_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_START_TWR: assert property (
    (state_q == ST_HUNT && frame_end && code == START_TWR)
    |=> state_q == ST_WR_TMR && !div_run_q ##1 div_q == '0)
    else $error("timer write start not taken");

  AST_START_TRD: assert property (
    (state_q == ST_HUNT && frame_end && code == START_TRD)
    |=> state_q == ST_READ && rd_q[STOP_LSB +: 8] == STOP_CODE)
    else $error("timer read start not taken");

  AST_START_CWR: assert property (
    (state_q == ST_HUNT && frame_end && code == START_CWR)
    |=> state_q == ST_WR_CTL)
    else $error("control write start not taken");

  AST_BAD_START: assert property (
    (state_q == ST_HUNT && frame_end && code != START_TWR &&
     code != START_TRD && code != START_CWR)
    |=> state_q == ST_HUNT && !pin_q.drive && $stable(ctrl_q))
    else $error("unknown start code changed state");

  AST_CTRL_LOAD: assert property (
    (state_q == ST_LD_CTL && sck_fall)
    |=> ctrl_q == $past(sr_q[CTRL_LSB +: CTRL_BITS]) && state_q == ST_HUNT)
    else $error("control data not loaded after stop");

  AST_TMR_LOAD: assert property (
    (state_q == ST_LD_TMR && sck_fall)
    |=> cal_load_q && div_run_q && state_q == ST_HUNT)
    else $error("timer load or divider restart missing");

  AST_READ_BIT: assert property (
    (state_q == ST_READ && sck_fall && rd_idx_q != RD_TOTAL)
    |=> pin_q.drive && !pin_q.pull_dn && pin_q.level == $past(rd_q[0]))
    else $error("read bit not driven on falling edge");

  AST_READ_END: assert property (
    (state_q == ST_READ && sck_fall && rd_idx_q == RD_TOTAL)
    |=> !pin_q.drive && pin_q.pull_dn && state_q == ST_HUNT)
    else $error("line not released after read stop");

  AST_WAKE: assert property (
    (tb_rise && wk_q == WAKE_LAST) ##1 ctrl_q[CTRL_WAKE_EN]
    |=> wake_q)
    else $error("wake-up pulse missing at period end");

  AST_WAKE_GATE: assert property (
    wake_q |-> $past(ctrl_q[CTRL_WAKE_EN]))
    else $error("wake-up pulsed while disabled");

  AST_SHIFT_IN: assert property (
    (sck_rise && state_q != ST_READ)
    |=> sr_q[SHIFT_BITS-1] == $past(sd))
    else $error("serial bit not shifted on rising edge");

  COV_TMR_WRITE: cover property (state_q == ST_LD_TMR && sck_fall);
  COV_CTRL_WRITE: cover property (state_q == ST_LD_CTL && sck_fall);
  COV_READ_DONE: cover property (
    state_q == ST_READ && sck_fall && rd_idx_q == RD_TOTAL);
  COV_WAKE: cover property ($rose(wake_q));

endmodule : rtcsc_top

// ===== tb/rtcsc_host.sv
// Purpose: Host processor model driving the serial clock and data line
// Assumes: Bit cell of eight clk cycles, four low and four high
// Notes: Data changes one clk after the serial fall, held across the rise
`timescale 1ns/1ps
module rtcsc_host (
  // System clock and resolved line
  input wire logic clk,
  input wire logic line,
  // Host pins
  output logic sck,
  output logic sd,
  output logic sd_oe
);
  import rtcsc_pkg::*;

  initial begin
    sck = 1'b0;
    sd = 1'b0;
    sd_oe = 1'b1;
  end

  // One bit cell; seen is the line just before the fall
  task automatic bit_cell(input logic b, output logic seen);
    @(posedge clk);
    #2 sd = b;
    repeat (3) @(posedge clk);
    #2 sck = 1'b1;
    repeat (4) @(posedge clk);
    #1 seen = line;
    #1 sck = 1'b0;
  endtask : bit_cell

  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_cell(b[i], s);
    end
    sd = 1'b0;
  endtask : send_byte

  task automatic send_time(input rtcsc_time_s t);
    logic s;
    for (int i = 0; i < TIMER_BITS; i++) begin
      bit_cell(t[i], s);
    end
    sd = 1'b0;
  endtask : send_time

  task automatic write_time(input rtcsc_time_s t, input logic extra);
    send_byte(START_TWR);
    if (extra) begin
      send_byte(8'h33);
    end
    send_time(t);
    send_byte(STOP_CODE);
    repeat (8) @(posedge clk);
  endtask : write_time

  task automatic write_ctrl(input logic [7:0] d);
    send_byte(START_CWR);
    send_byte(d);
    send_byte(STOP_CODE);
    repeat (8) @(posedge clk);
  endtask : write_ctrl

  // Host sends only the start code; device supplies the stop code
  task automatic read_frame(output logic [63:0] v);
    send_byte(START_TRD);
    sd_oe = 1'b0;
    for (int i = 0; i < 64; i++) begin
      bit_cell(1'b0, v[i]);
    end
    repeat (8) @(posedge clk);
    #2 sd_oe = 1'b1;
  endtask : read_frame
endmodule : rtcsc_host

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the serial calendar clock front end
// Assumes: Time base period six clk cycles, small divider parameter
// Notes: Expected values worked out from the BCD calendar by hand
`timescale 1ns/1ps
module testbench;
  import rtcsc_pkg::*;

  localparam int TB_HZ = 2800;
  localparam int TB_HALF = 3;
  localparam int WAKE_PER = (TB_HZ * WAKE_US / US_PER_S) * 2 * TB_HALF;

  logic clk;
  logic rst;
  logic tb_in;
  logic line;
  logic host_sck;
  logic host_sd;
  logic host_oe;
  logic wake;
  rtcsc_pin_s pin;
  int num_errors;
  int num_checks;

  // Weak pull-down wins only when nobody drives
  assign line = pin.drive ? pin.level : (host_oe ? host_sd : 1'b0);

  rtcsc_top #(.TIMEBASE_HZ(TB_HZ)) dut (
    .clk(clk),
    .rst(rst),
    .ext_timebase_in(tb_in),
    .ser_clk_in(host_sck),
    .ser_data_in(line),
    .ser_data_pin(pin),
    .wake_pull_low(wake)
  );

  rtcsc_host host (
    .clk(clk),
    .line(line),
    .sck(host_sck),
    .sd(host_sd),
    .sd_oe(host_oe)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    tb_in = 1'b0;
    forever begin
      repeat (TB_HALF) @(posedge clk);
      #2 tb_in = ~tb_in;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic check_read(input rtcsc_time_s exp);
    logic [63:0] v;
    host.read_frame(v);
    check(v[55:0], exp);
    check(v[63:56], STOP_CODE);
    check({pin.drive, pin.pull_dn}, 2'b01);
  endtask : check_read

  // Length of one wake pulse and of one whole period
  task automatic wake_gap(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    per = 0;
    while (wake !== 1'b0 && n < 200) begin
      step;
      n++;
    end
    while (wake !== 1'b1 && n < 200) begin
      step;
      n++;
    end
    while (wake === 1'b1 && hi < 200) begin
      step;
      hi++;
    end
    per = hi;
    while (wake !== 1'b1 && per < 200) begin
      step;
      per++;
    end
  endtask : wake_gap

  task automatic t_reset;
    rst = 1'b1;
    repeat (3) step;
    check({pin, wake}, 4'h2);
    #1 rst = 1'b0;
    repeat (4) step;
    check(pin, 3'h1);
    $display("Test reset done");
  endtask : t_reset

  task automatic t_write_read;
    // Extra leading byte, invalid fields, unused bit set in day of week
    host.write_time('{8'h99, 8'h04, 8'h31, 8'h81, 8'h24, 8'h12, 8'h75},
                    1'b1);
    host.send_byte(8'h5E);
    repeat (6) step;
    check(pin, 3'h1);
    check_read('{8'h99, 8'h04, 8'h01, 8'h01, 8'h00, 8'h12,
                 8'h00});
    $display("Test write and read done");
  endtask : t_write_read

  task automatic t_wake_ctrl;
    int hi;
    int per;
    int seen;
    host.write_time('{8'h10, 8'h06, 8'h15, 8'h02, 8'h08, 8'h30, 8'h45},
                    1'b0);
    wake_gap(hi, per);
    check(hi, 2 * TB_HALF);
    check(per, WAKE_PER);
    // Last four bits are zero, first four are ones
    host.write_ctrl(8'h0F);
    seen = 0;
    repeat (5 * WAKE_PER) begin
      step;
      if (wake !== 1'b0) begin
        seen++;
      end
    end
    check(seen, 0);
    host.write_ctrl(8'h10);
    wake_gap(hi, per);
    check(per, WAKE_PER);
    check_read('{8'h10, 8'h06, 8'h15, 8'h02, 8'h08, 8'h30, 8'h45});
    $display("Test wake and control done");
  endtask : t_wake_ctrl

  task automatic t_tick;
    rtcsc_time_s tin [3];
    rtcsc_time_s tout [3];
    tin[0] = '{8'h24, 8'h02, 8'h28, 8'h07, 8'h23, 8'h59, 8'h59};
    tout[0] = '{8'h24, 8'h02, 8'h29, 8'h01, 8'h00, 8'h00, 8'h00};
    tin[1] = '{8'h23, 8'h02, 8'h28, 8'h03, 8'h23, 8'h59, 8'h59};
    tout[1] = '{8'h23, 8'h03, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00};
    tin[2] = '{8'h99, 8'h12, 8'h31, 8'h05, 8'h23, 8'h59, 8'h59};
    tout[2] = '{8'h00, 8'h01, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++) begin
      host.write_time(tin[i], 1'b0);
      repeat (TB_HZ * 2 * TB_HALF + 200) step;
      check_read(tout[i]);
    end
    $display("Test calendar tick done");
  endtask : t_tick

  initial begin
    num_errors = 0;
    num_checks = 0;
    rst = 1'b1;
    t_reset;
    t_write_read;
    t_wake_ctrl;
    t_tick;
    results;
  end

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("Watchdog expired");
    results;
  end
endmodule : testbench
